/* rtl/uet_host_ctrl.sv */
// Controller that drives one device endpoint through its status and data registers.
// Assumes the device answers a register read in the cycle after the strobe and never stalls.
// Software steers it through a small register port of its own.
//
// The register addresses and the address-and-strobe port are this design's own decisions.

module uet_host_ctrl (
  input wire logic ref_clk,
  input wire logic rstn,
  input uet_pkg::uet_bus_t sw_req,
  output logic [31:0] sw_rdata,
  output uet_pkg::uet_bus_t dev_req,
  input wire logic [31:0] dev_rdata,
  input wire logic dev_irq,
  output logic busy
);
  import uet_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RDW, S_POLL_D, S_SU_D, S_CHK_D, S_IN_WR, S_CCLR} uet_state_t;

  // Whole controller state in one word
  typedef struct packed {
    uet_state_t state;
    uet_state_t ret;
    uet_bus_t dev;
    logic [31:0] rdata;
    uet_cfg_t cfg;
    logic go;
    logic last;
    logic stall_req;
    logic [6:0] len;
    logic [6:0] idx;
    logic [6:0] wr_idx;
    logic wait_comp;
    logic comp_seen;
    logic last_act;
    logic setup_avail;
    logic tx_done;
    logic cfg_err;
    uet_stage_t stage;
    logic [6:0] tick_cnt;
  } uet_st_t;

  logic [1:0] rst_sync_r; // Reset release stages
  logic rst_n; // Synchronised reset
  uet_st_t s; // Registered state
  uet_st_t n; // Next state
  logic cfg_ok; // Endpoint configuration fits its type
  logic [8*SETUP_LEN-1:0] su_flat; // Captured setup packet
  logic [8*TX_DEPTH-1:0] tx_flat; // Payload to send
  logic su_we; // Store one setup byte
  logic tx_we; // Store one payload byte
  logic [7:0] csr_addr; // Device status word of the endpoint
  logic [7:0] fdr_addr; // Device data word of the endpoint
  logic is_ctrl; // Endpoint carries control transfers
  logic bad_ctl; // Send request does not fit the control stage
  logic su_set, done_set, err_set; // Sticky set events
  logic [15:0] su_wlen; // Announced data stage length

  // Reset is released through two flops so every flop leaves reset on one edge
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync_r <= 2'b00;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign csr_addr = DEV_CSR + {3'h0, s.cfg.ep, 2'b00};
  assign fdr_addr = DEV_FDR + {3'h0, s.cfg.ep, 2'b00};
  assign is_ctrl = s.cfg.xfer == XFER_CTRL;
  assign su_wlen = {su_flat[63:56], su_flat[55:48]};
  assign tx_we = sw_req.wr && sw_req.addr == R_TXD && !s.go && s.wr_idx < 7'(TX_DEPTH);

  uet_cfg_check u_cfg (
    .cfg(s.cfg),
    .ok(cfg_ok)
  );

  uet_byte_buf #(.DEPTH(SETUP_LEN), .IW(3)) u_su_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .we(su_we),
    .widx(s.idx[2:0]),
    .wdata(dev_rdata[7:0]),
    .flat(su_flat)
  );

  uet_byte_buf #(.DEPTH(TX_DEPTH), .IW(6)) u_tx_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .we(tx_we),
    .widx(s.wr_idx[5:0]),
    .wdata(sw_req.wdata[7:0]),
    .flat(tx_flat)
  );

  // Control transfers: only IN data in a data-in stage, else a zero-length status IN
  always_comb
  begin
    bad_ctl = is_ctrl && !(s.stage == STG_DATA_IN ||
      (s.len == 7'h00 && (s.stage == STG_STATUS_IN || s.stage == STG_DATA_OUT)));
  end

  // Next-state logic: software port, device sequencing and sticky flags
  always_comb
  begin
    n = s;
    n.dev = '0;
    n.rdata = '0;
    su_we = 1'b0;
    su_set = 1'b0;
    done_set = 1'b0;
    err_set = 1'b0;
    n.tick_cnt = (s.tick_cnt == 7'(POLL_CYC - 1)) ? 7'h00 : s.tick_cnt + 7'h01;
    // Software reads answer in the following cycle
    if (sw_req.rd)
    begin
      case (sw_req.addr)
        R_CTRL: n.rdata = {7'h00, s.cfg.size, 8'h00, s.cfg.configured, s.cfg.dual, s.cfg.xfer, 1'b0, s.cfg.ep};
        R_CMD: n.rdata = {17'h00000, s.len, 5'h00, s.stall_req, s.last, s.go};
        R_STAT: n.rdata = {23'h000000, s.stage, s.wait_comp, busy, s.go, s.cfg_err, s.tx_done, s.setup_avail};
        R_SU_LO: n.rdata = su_flat[31:0];
        R_SU_HI: n.rdata = su_flat[63:32];
        default: n.rdata = '0;
      endcase
    end
    // Software writes; configuration is held still while a send is pending
    if (sw_req.wr)
    begin
      case (sw_req.addr)
        R_CTRL:
        begin
          if (!s.go)
          begin
            n.cfg.ep = sw_req.wdata[CTRL_EP_LSB +: 3];
            n.cfg.xfer = uet_xfer_t'(sw_req.wdata[CTRL_XFER_LSB +: 2]);
            n.cfg.dual = sw_req.wdata[CTRL_DUAL];
            n.cfg.configured = sw_req.wdata[CTRL_CONF];
            n.cfg.size = sw_req.wdata[CTRL_SIZE_LSB +: 9];
          end
        end
        R_CMD:
        begin
          if (sw_req.wdata[CMD_STALL])
          begin
            n.stall_req = 1'b1;
          end
          // A second send while one is pending is ignored
          if (sw_req.wdata[CMD_GO] && !s.go)
          begin
            n.go = 1'b1;
            n.last = sw_req.wdata[CMD_LAST];
            n.len = sw_req.wdata[CMD_LEN_LSB +: 7];
          end
        end
        R_STAT:
        begin
          if (sw_req.wdata[ST_SETUP])
          begin
            n.setup_avail = 1'b0;
          end
          if (sw_req.wdata[ST_DONE])
          begin
            n.tx_done = 1'b0;
          end
          if (sw_req.wdata[ST_ERR])
          begin
            n.cfg_err = 1'b0;
          end
        end
        R_TXD:
        begin
          if (tx_we)
          begin
            n.wr_idx = s.wr_idx + 7'h01;
          end
        end
        default:
        begin
          n.wr_idx = n.wr_idx;
        end
      endcase
    end
    // Device side sequencing
    unique case (s.state)
      S_IDLE:
      begin
        if (s.stall_req)
        begin
          // Stall aborts the control transfer in progress
          n.dev = '{wr: 1'b1, rd: 1'b0, addr: csr_addr, wdata: CSR_KEEP | (32'h1 << CSR_STALL)};
          n.stall_req = 1'b0;
          n.stage = STG_IDLE;
        end
        else if (s.go && !s.wait_comp)
        begin
          if (!cfg_ok || {2'b00, s.len} > s.cfg.size || bad_ctl)
          begin
            n.go = 1'b0;
            err_set = 1'b1;
            n.wr_idx = 7'h00; // Refused payload is dropped so it cannot ride along with the next send
          end
          else
          begin
            n.dev = '{wr: 1'b0, rd: 1'b1, addr: csr_addr, wdata: 32'h0};
            n.ret = S_CHK_D;
            n.state = S_RDW;
          end
        end
        else if (s.tick_cnt == 7'h00 || dev_irq)
        begin
          n.dev = '{wr: 1'b0, rd: 1'b1, addr: csr_addr, wdata: 32'h0};
          n.ret = S_POLL_D;
          n.state = S_RDW;
        end
      end
      S_RDW:
      begin
        n.state = s.ret;
      end
      S_POLL_D:
      begin
        n.state = S_IDLE;
        // A setup is fetched only once the previous one has been taken by software
        if (dev_rdata[CSR_SETUP] && !s.setup_avail)
        begin
          n.idx = 7'h00;
          n.dev = '{wr: 1'b0, rd: 1'b1, addr: fdr_addr, wdata: 32'h0};
          n.ret = S_SU_D;
          n.state = S_RDW;
        end
        else if (dev_rdata[CSR_COMP] && s.wait_comp)
        begin
          n.wait_comp = 1'b0;
          n.comp_seen = 1'b1;
          done_set = 1'b1;
          if (is_ctrl)
          begin
            n.stage = (s.stage == STG_DATA_IN && s.last_act) ? STG_STATUS_OUT :
              (s.stage == STG_DATA_IN) ? STG_DATA_IN : STG_IDLE;
          end
          if (s.last_act)
          begin
            n.state = S_CCLR;
          end
        end
      end
      S_SU_D:
      begin
        su_we = 1'b1;
        if (s.idx == 7'(SETUP_LEN - 1))
        begin
          // Last byte is in hand, so the device may now reuse its buffer
          n.dev = '{wr: 1'b1, rd: 1'b0, addr: csr_addr, wdata: CSR_KEEP & ~(32'h1 << CSR_SETUP)};
          su_set = 1'b1;
          if ({dev_rdata[7:0], su_wlen[7:0]} == 16'h0000)
          begin
            n.stage = STG_STATUS_IN;
          end
          else
          begin
            n.stage = su_flat[7] ? STG_DATA_IN : STG_DATA_OUT;
          end
          n.state = S_IDLE;
        end
        else
        begin
          n.idx = s.idx + 7'h01;
          n.dev = '{wr: 1'b0, rd: 1'b1, addr: fdr_addr, wdata: 32'h0};
          n.ret = S_SU_D;
          n.state = S_RDW;
        end
      end
      S_CHK_D:
      begin
        // Device still holds the last packet: retry on a later pass
        n.state = S_IDLE;
        if (!dev_rdata[CSR_TXRDY])
        begin
          n.idx = 7'h00;
          n.state = S_IN_WR;
        end
      end
      S_IN_WR:
      begin
        if (s.idx == s.len)
        begin
          n.dev = '{wr: 1'b1, rd: 1'b0, addr: csr_addr, wdata: CSR_KEEP | (32'h1 << CSR_TXRDY)};
          n.wait_comp = 1'b1;
          n.go = 1'b0;
          n.last_act = s.last;
          n.wr_idx = 7'h00;
          n.state = s.comp_seen ? S_CCLR : S_IDLE;
        end
        else
        begin
          n.dev = '{wr: 1'b1, rd: 1'b0, addr: fdr_addr, wdata: {24'h0, tx_flat[s.idx[5:0]*8 +: 8]}};
          n.idx = s.idx + 7'h01;
        end
      end
      S_CCLR:
      begin
        n.dev = '{wr: 1'b1, rd: 1'b0, addr: csr_addr, wdata: CSR_KEEP & ~(32'h1 << CSR_COMP)};
        n.comp_seen = 1'b0;
        n.state = S_IDLE;
      end
    endcase
    // Hardware events win over a software clear in the same cycle
    if (su_set)
    begin
      n.setup_avail = 1'b1;
    end
    if (done_set)
    begin
      n.tx_done = 1'b1;
    end
    if (err_set)
    begin
      n.cfg_err = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{state: S_IDLE, ret: S_IDLE, cfg: CFG_RST, stage: STG_IDLE, default: '0};
    end
    else
    begin
      s <= n;
    end
  end

  assign dev_req = s.dev;
  assign sw_rdata = s.rdata;
  assign busy = s.state != S_IDLE || s.go || s.wait_comp;

  // Helper logic watched only by the checks below
  logic csr_wr, clr_su, clr_comp, set_rdy, fdr_wr, fdr_rd;
  logic [3:0] su_rd_h;
  logic [6:0] fdr_cnt_h;
  logic rd_csr_h, free_h, rdy_h;
  assign csr_wr = dev_req.wr && dev_req.addr == csr_addr;
  assign clr_su = csr_wr && !dev_req.wdata[CSR_SETUP];
  assign clr_comp = csr_wr && !dev_req.wdata[CSR_COMP];
  assign set_rdy = csr_wr && dev_req.wdata[CSR_TXRDY];
  assign fdr_wr = dev_req.wr && dev_req.addr == fdr_addr;
  assign fdr_rd = dev_req.rd && dev_req.addr == fdr_addr;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      su_rd_h <= 4'h0;
      fdr_cnt_h <= 7'h00;
      rd_csr_h <= 1'b0;
      free_h <= 1'b0;
      rdy_h <= 1'b0;
    end
    else
    begin
      su_rd_h <= clr_su ? 4'h0 : su_rd_h + {3'h0, fdr_rd};
      fdr_cnt_h <= set_rdy ? 7'h00 : fdr_cnt_h + {6'h00, fdr_wr};
      rd_csr_h <= dev_req.rd && dev_req.addr == csr_addr;
      free_h <= set_rdy ? 1'b0 : (free_h || (rd_csr_h && !dev_rdata[CSR_TXRDY]));
      rdy_h <= clr_comp ? 1'b0 : (rdy_h || set_rdy);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_last_seen;
    // A pending setup is fetched first and the completion is taken on a later poll
    s.state == S_POLL_D && dev_rdata[CSR_COMP] && s.wait_comp && s.last_act &&
      (s.setup_avail || !dev_rdata[CSR_SETUP]);
  endsequence
  sequence s_comp_clr;
    clr_comp;
  endsequence

  property p_setup_read;
    clr_su |-> su_rd_h == 4'h8;
  endproperty
  a_setup_read: assert property (p_setup_read) else $error("setup flag cleared before all bytes read");

  property p_load_free;
    fdr_wr |-> free_h;
  endproperty
  a_load_free: assert property (p_load_free) else $error("payload written while packet-ready set");

  property p_byte_count;
    set_rdy |-> fdr_cnt_h == s.len;
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("byte count differs from length");

  property p_rdy_arm;
    set_rdy |-> $rose(s.wait_comp) && !s.go;
  endproperty
  a_rdy_arm: assert property (p_rdy_arm) else $error("ready set without arming completion wait");

  property p_comp_order;
    // The closing clear after the final packet has no following ready
    clr_comp |-> rdy_h || (s.last_act && !s.wait_comp);
  endproperty
  a_comp_order: assert property (p_comp_order) else $error("completion cleared before ready set");

  property p_last_clr;
    s_last_seen |-> ##[1:3] s_comp_clr;
  endproperty
  a_last_clr: assert property (p_last_clr) else $error("completion not cleared after last packet");

  property p_stall;
    s.stall_req && s.state == S_IDLE |=> csr_wr && dev_req.wdata[CSR_STALL] && s.stage == STG_IDLE;
  endproperty
  a_stall: assert property (p_stall) else $error("stall request not issued");
endmodule : uet_host_ctrl

/* rtl/uet_pkg.sv */
// Shared constants and types for the endpoint transaction controller.
// Assumes a single 50 MHz clock and a device register port that answers reads one cycle later.
package uet_pkg;
  // Clock and polling rate
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned POLL_NS = 2000;
  localparam int unsigned POLL_CYC = POLL_NS / CLK_PERIOD_NS;
  // Device register map: one status word and one data word per endpoint
  localparam logic [7:0] DEV_CSR = 8'h30;
  localparam logic [7:0] DEV_FDR = 8'h50;
  // Endpoint status word bits
  localparam int CSR_COMP = 0;
  localparam int CSR_SETUP = 2;
  localparam int CSR_TXRDY = 4;
  localparam int CSR_STALL = 5;
  // Flag bits written as one keep their value, written as zero clear
  localparam logic [31:0] CSR_KEEP = 32'h0000_0005;
  // Software register offsets
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_CMD = 8'h04;
  localparam logic [7:0] R_STAT = 8'h08;
  localparam logic [7:0] R_TXD = 8'h0c;
  localparam logic [7:0] R_SU_LO = 8'h10;
  localparam logic [7:0] R_SU_HI = 8'h14;
  // Control register fields
  localparam int CTRL_EP_LSB = 0;
  localparam int CTRL_XFER_LSB = 4;
  localparam int CTRL_DUAL = 6;
  localparam int CTRL_CONF = 7;
  localparam int CTRL_SIZE_LSB = 16;
  // Command register fields
  localparam int CMD_GO = 0;
  localparam int CMD_LAST = 1;
  localparam int CMD_STALL = 2;
  localparam int CMD_LEN_LSB = 8;
  // Status register write-one-to-clear bits
  localparam int ST_SETUP = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  // Sizes
  localparam int SETUP_LEN = 8;
  localparam int TX_DEPTH = 64;
  localparam logic [8:0] ISO_SIZE = 9'h100;
  localparam logic [8:0] INT_MAX = 9'h040;

  typedef enum logic [1:0] {XFER_CTRL, XFER_ISO, XFER_INT, XFER_BULK} uet_xfer_t;
  typedef enum logic [2:0] {STG_IDLE, STG_DATA_IN, STG_DATA_OUT, STG_STATUS_IN, STG_STATUS_OUT} uet_stage_t;

  // One register access, used both toward the device and from software
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } uet_bus_t;

  // Endpoint configuration as software sets it
  typedef struct packed {
    logic configured;
    logic dual;
    uet_xfer_t xfer;
    logic [2:0] ep;
    logic [8:0] size;
  } uet_cfg_t;

  localparam uet_cfg_t CFG_RST = '{configured: 1'b0, dual: 1'b0, xfer: XFER_CTRL, ep: 3'h0, size: 9'h008};
endpackage : uet_pkg

/* rtl/uet_byte_buf.sv */
// Byte store held in flip-flops, written by index, visible whole.
// Assumes the caller keeps the index inside the depth.
module uet_byte_buf #(
  parameter int DEPTH = 8,
  parameter int IW = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [IW-1:0] widx,
  input wire logic [7:0] wdata,
  output logic [DEPTH*8-1:0] flat
);
  import uet_pkg::*;

  logic [DEPTH*8-1:0] mem_r; // Stored bytes
  logic [DEPTH*8-1:0] mem_nxt; // Next contents

  // One byte lane changes per write
  always_comb
  begin
    mem_nxt = mem_r;
    if (we)
    begin
      mem_nxt[widx*8 +: 8] = wdata;
    end
  end

  // Contents clear at reset so a read before any fill is defined
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
    end
  end

  assign flat = mem_r;
endmodule : uet_byte_buf

/* rtl/uet_cfg_check.sv */
// Checks that an endpoint's transfer type, bank mode and size fit together.
// Purely combinational; the caller refuses work when ok is low.
module uet_cfg_check (
  input uet_pkg::uet_cfg_t cfg,
  output logic ok
);
  import uet_pkg::*;

  logic std_size; // One of the four packet sizes

  // Decide per transfer type
  always_comb
  begin
    std_size = cfg.size inside {9'h008, 9'h010, 9'h020, 9'h040};
    ok = 1'b0;
    unique case (cfg.xfer)
      XFER_CTRL: ok = !cfg.dual && std_size;
      XFER_ISO: ok = cfg.dual && cfg.size == ISO_SIZE;
      XFER_INT: ok = cfg.size != 9'h000 && cfg.size <= INT_MAX;
      XFER_BULK: ok = std_size;
    endcase
    // Before configuration only the default control endpoint may run
    if (!cfg.configured && (cfg.ep != 3'h0 || cfg.xfer != XFER_CTRL))
    begin
      ok = 1'b0;
    end
  end
endmodule : uet_cfg_check

/* verification/uet_dev_model.sv */
// Behavioural endpoint device seen through its status and data registers, with a host on its bus side.
// Assumes one clock shared with the controller; the bench fires host setup and IN tokens as pulses.
module uet_dev_model
(
  input wire logic ref_clk,
  input wire logic rstn,
  input uet_pkg::uet_bus_t dev_req,
  output logic [31:0] dev_rdata,
  output logic dev_irq,
  input wire logic host_setup,
  input wire logic [63:0] setup_bytes,
  input wire logic host_in,
  output logic [6:0] pkt_len,
  output logic [63:0] pkt_data,
  output logic last_pid,
  output logic comp,
  output logic txrdy,
  output logic stall,
  output logic setup_flag,
  output logic clr_rdy,
  output int naks,
  output int bad
);
  timeunit 1ns;
  timeprecision 1ns;
  import uet_pkg::*;
  logic [7:0] fifo [TX_DEPTH]; // Transmit payload store
  logic [6:0] widx; // Next byte slot
  logic [63:0] su; // Stored setup packet
  logic [3:0] rdcnt; // Setup bytes read out so far
  logic pid; // Data toggle for the next IN packet
  logic is_csr;
  logic is_fdr;
  assign is_csr = dev_req.addr >= DEV_CSR && dev_req.addr < DEV_FDR;
  assign is_fdr = dev_req.addr >= DEV_FDR && dev_req.addr < 8'h70;
  // Interrupt held while either flag stands
  assign dev_irq = comp | setup_flag;
  // Register port and host events on one clock, standing for both device clock domains;
  // host events come last so they win over a register write in the same cycle
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {dev_rdata, pkt_len, pkt_data, last_pid, comp, txrdy, stall, setup_flag, clr_rdy} <= '0;
      {widx, su, rdcnt, pid, naks, bad} <= '0;
    end
    else
    begin
      // Undriven read data toggles so a late sample never looks right
      dev_rdata <= ~dev_rdata;
      if (dev_req.rd && is_csr)
        dev_rdata <= {26'h0, stall, txrdy, 1'b0, setup_flag, 1'b0, comp};
      if (dev_req.rd && is_fdr)
      begin
        dev_rdata <= {24'h0, su[rdcnt[2:0]*8 +: 8]};
        rdcnt <= rdcnt + 4'h1;
      end
      if (dev_req.wr && is_fdr)
      begin
        if (txrdy)
          bad <= bad + 1;
        fifo[widx[5:0]] <= dev_req.wdata[7:0];
        widx <= widx + 7'h1;
      end
      if (dev_req.wr && is_csr)
      begin
        if (comp && !dev_req.wdata[CSR_COMP])
          clr_rdy <= txrdy;
        if (setup_flag && !dev_req.wdata[CSR_SETUP] && rdcnt < 4'h8)
          bad <= bad + 1;
        comp <= comp & dev_req.wdata[CSR_COMP];
        setup_flag <= setup_flag & dev_req.wdata[CSR_SETUP];
        txrdy <= txrdy | dev_req.wdata[CSR_TXRDY];
        stall <= stall | dev_req.wdata[CSR_STALL];
      end
      // Setup is acknowledged at once, whatever the processor is doing
      if (host_setup)
      begin
        {su, setup_flag, rdcnt, stall, pid} <= {setup_bytes, 1'b1, 4'h0, 1'b0, 1'b1};
      end
      // IN token: stall, send and take the ACK, or refuse with NAK
      if (host_in && !stall && txrdy)
      begin
        pkt_len <= widx;
        pkt_data <= {fifo[7], fifo[6], fifo[5], fifo[4], fifo[3], fifo[2], fifo[1], fifo[0]};
        {last_pid, pid, txrdy, comp, widx} <= {pid, ~pid, 1'b0, 1'b1, 7'h0};
      end
      else if (host_in && !stall)
        naks <= naks + 1;
    end
  end
endmodule : uet_dev_model

/* verification/test_usb_fs_endpoint_transaction_handler.sv */
// Self-checking bench for the endpoint controller facing a behavioural device.
// Assumes the controller answers software reads one cycle later and polls the device on its own.
module test_usb_fs_endpoint_transaction_handler;
  timeunit 1ns;
  timeprecision 1ns;
  import uet_pkg::*;
  logic ref_clk, rstn, busy, dev_irq, host_setup, host_in;
  logic last_pid, comp, txrdy, stall, setup_flag, clr_rdy;
  uet_bus_t sw_req, dev_req;
  logic [31:0] sw_rdata, dev_rdata, d;
  logic [63:0] setup_bytes, pkt_data;
  logic [6:0] pkt_len;
  int naks, bad, errors, checks, n0;
  // Endpoint setups: the first six break a fit rule, the last three are legal
  localparam logic [31:0] CFG_TBL [9] = '{32'h0008_0040, 32'h0100_0091, 32'h0040_00d1, 32'h0080_00a1,
    32'h0030_00b1, 32'h0040_0031, 32'h0100_00d1, 32'h0040_00a1, 32'h0020_00b1};
  localparam logic [0:8] CFG_BAD = 9'b111111000;
  uet_host_ctrl DUT (.ref_clk(ref_clk), .rstn(rstn), .sw_req(sw_req), .sw_rdata(sw_rdata), .dev_req(dev_req),
    .dev_rdata(dev_rdata), .dev_irq(dev_irq), .busy(busy));
  uet_dev_model dev (.ref_clk(ref_clk), .rstn(rstn), .dev_req(dev_req), .dev_rdata(dev_rdata), .dev_irq(dev_irq),
    .host_setup(host_setup), .setup_bytes(setup_bytes), .host_in(host_in), .pkt_len(pkt_len), .pkt_data(pkt_data),
    .last_pid(last_pid), .comp(comp), .txrdy(txrdy), .stall(stall), .setup_flag(setup_flag), .clr_rdy(clr_rdy),
    .naks(naks), .bad(bad));
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  // Prints the counts and the verdict, then stops
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // Compares one value, case equality so unknowns fail
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  // One-cycle write strobe
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    sw_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge ref_clk);
    sw_req <= '0;
  endtask : sw_wr
  // One-cycle read strobe; data is taken in the following cycle only
  task automatic sw_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    sw_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    sw_req <= '0;
    #1;
    v = sw_rdata;
  endtask : sw_rd
  // Host events as single-cycle pulses
  task automatic pulse_in();
    @(posedge ref_clk);
    host_in <= 1'b1;
    @(posedge ref_clk);
    host_in <= 1'b0;
  endtask : pulse_in
  task automatic pulse_setup(input logic [63:0] b);
    @(posedge ref_clk);
    setup_bytes <= b;
    host_setup <= 1'b1;
    @(posedge ref_clk);
    host_setup <= 1'b0;
  endtask : pulse_setup
  // Bounded poll of one status bit
  task automatic wait_stat(input int b);
    int i;
    for (i = 0; i < 300; i++)
    begin
      sw_rd(R_STAT, d);
      if (d[b] === 1'b1)
        break;
    end
    if (i == 300)
    begin
      errors++;
      $display("[FAIL] status bit %0d expected 1 seen timeout", b);
      test_done();
    end
  endtask : wait_stat
  task automatic stage_chk(input uet_stage_t s);
    sw_rd(R_STAT, d);
    chk("stage", {29'h0, s}, {29'h0, d[8:6]});
  endtask : stage_chk
  // Reset values, an unmapped read
  task automatic t_reset();
    sw_rd(R_CTRL, d);
    chk("ctrl reset", 32'h0008_0000, d);
    sw_rd(R_STAT, d);
    chk("stat reset", 32'h0, d);
    sw_rd(8'h20, d);
    chk("unmapped", 32'h0, d);
  endtask : t_reset
  // Every endpoint setup in the table, legal ones sent through the device
  task automatic t_cfg();
    for (int i = 0; i < 9; i++)
    begin
      sw_wr(R_CTRL, CFG_TBL[i]);
      sw_wr(R_TXD, 32'h0000_005a);
      sw_wr(R_CMD, 32'h0000_0103);
      idle(40);
      sw_rd(R_STAT, d);
      chk("cfg_err", {31'h0, CFG_BAD[i]}, {31'h0, d[ST_ERR]});
      if (!CFG_BAD[i])
      begin
        pulse_in();
        wait_stat(ST_DONE);
        chk("pkt byte", 32'h0000_015a, {17'h0, pkt_len, pkt_data[7:0]});
      end
      sw_wr(R_STAT, 32'h0000_0007);
    end
    sw_wr(R_CTRL, 32'h0008_0000);
  endtask : t_cfg
  // Control read: setup, two IN packets, then the status OUT stage
  task automatic t_ctrl_in();
    pulse_setup(64'h0006_0000_0100_0680);
    wait_stat(ST_SETUP);
    sw_rd(R_SU_LO, d);
    chk("setup lo", 32'h0100_0680, d);
    sw_rd(R_SU_HI, d);
    chk("setup hi", 32'h0006_0000, d);
    chk("setup flag", 32'h0, {31'h0, setup_flag});
    stage_chk(STG_DATA_IN);
    sw_wr(R_STAT, 32'h0000_0001);
    for (int i = 1; i < 5; i++)
      sw_wr(R_TXD, 32'(i * 8'h11));
    n0 = naks;
    pulse_in();
    #1;
    chk("nak", n0 + 1, naks);
    sw_wr(R_CMD, 32'h0000_0401);
    #1;
    chk("busy", 32'h1, {31'h0, busy});
    idle(40);
    chk("ready", 32'h1, {31'h0, txrdy});
    pulse_in();
    idle(2);
    chk("pkt1", 32'h4433_2211, pkt_data[31:0]);
    chk("len1", 32'h4, {25'h0, pkt_len});
    wait_stat(ST_DONE);
    sw_wr(R_STAT, 32'h0000_0002);
    sw_wr(R_TXD, 32'h0000_0055);
    sw_wr(R_TXD, 32'h0000_0066);
    sw_wr(R_CMD, 32'h0000_0203);
    idle(40);
    chk("comp cleared after ready", 32'h1, {30'h0, comp, clr_rdy});
    pulse_in();
    wait_stat(ST_DONE);
    idle(10);
    chk("pkt2", 32'h0002_6655, {9'h0, pkt_len, pkt_data[15:0]});
    chk("final comp", 32'h0, {31'h0, comp});
    stage_chk(STG_STATUS_OUT);
    sw_wr(R_STAT, 32'h0000_0002);
  endtask : t_ctrl_in
  // Control with no data: a non-empty send is refused, the empty one goes out as DATA1
  task automatic t_status_in();
    pulse_setup(64'h0000_0000_0001_0900);
    wait_stat(ST_SETUP);
    stage_chk(STG_STATUS_IN);
    sw_wr(R_STAT, 32'h0000_0001);
    sw_wr(R_TXD, 32'h0000_0077);
    sw_wr(R_CMD, 32'h0000_0103);
    idle(10);
    sw_rd(R_STAT, d);
    chk("refused", 32'h1, {31'h0, d[ST_ERR]});
    sw_wr(R_STAT, 32'h0000_0004);
    sw_wr(R_CMD, 32'h0000_0003);
    idle(40);
    pulse_in();
    idle(2);
    chk("zero length data1", 32'h1, {24'h0, pkt_len, last_pid});
    wait_stat(ST_DONE);
    sw_wr(R_STAT, 32'h0000_0007);
  endtask : t_status_in
  // Abort by stall
  task automatic t_stall();
    sw_wr(R_CMD, 32'h0000_0004);
    idle(20);
    chk("stall", 32'h1, {31'h0, stall});
    sw_rd(R_CMD, d);
    chk("cmd", 32'h0000_0002, d);
  endtask : t_stall
  // Main sequence
  initial
  begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    sw_req = '0;
    host_setup = 1'b0;
    host_in = 1'b0;
    setup_bytes = '0;
    errors = 0;
    checks = 0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    idle(4);
    t_reset();
    t_cfg();
    t_ctrl_in();
    t_status_in();
    t_stall();
    chk("device faults", 32'h0, bad);
    test_done();
  end
endmodule : test_usb_fs_endpoint_transaction_handler
